// File: logic/rtcc_ctrl.sv
// Purpose: rtc control, alarm, set/capture and oscillator config registers
// Assumes: classic wishbone slave, one ack cycle after request
// Notes: timer transfers wait for the next slow tick
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_map.svh"
module rtcc_ctrl #(
    parameter logic [3:0] LOAD_CAP_RST = 4'h0,
    parameter logic [6:0] PIN_RSV_RST = 7'h00
) (
    input wire logic clk_i,              // system clock, 40 MHz
    input wire logic rst_i,              // sync reset, active high
    input wire logic wb_cyc_i,           // bus cycle
    input wire logic wb_stb_i,           // strobe
    input wire logic wb_we_i,            // write enable
    input wire logic [3:0] wb_sel_i,     // byte lanes
    input wire logic [7:0] wb_adr_i,     // byte address
    input wire logic [31:0] wb_dat_i,    // write data
    output logic [31:0] wb_dat_o,        // read data
    output logic wb_ack_o,               // acknowledge
    input wire logic rtc_tick_i,         // one pulse per slow clock
    input wire logic osc_amp_ok_i,       // amplitude detector
    output logic alarm_event_o,          // alarm event flag
    output logic agc_enable_o,           // gain control on
    output logic crystal_mode_o,         // crystal mode in use
    output logic bias_double_o,          // bias doubling on
    output logic lfo_select_o,           // slow internal osc in use
    output logic xtal_pin_short_o,       // crystal pins shorted
    output logic [3:0] load_cap_o        // applied load cap code
);

    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;

    // control bits and sequencer
    logic alarm_enable_bit_r;
    logic alarm_enable_bit_nxt;
    logic auto_reset_r;
    logic auto_reset_nxt;
    logic alarm_flag_r;
    logic alarm_flag_nxt;
    logic timer_set_request_r;
    logic timer_set_request_nxt;
    logic timer_capture_request_r;
    logic timer_capture_request_nxt;
    rtcc_pkg::rtcc_op_t op_r;
    rtcc_pkg::rtcc_op_t op_nxt;
    logic [7:0] cap_r [4];
    logic [7:0] cap_nxt [4];
    logic [7:0] alm_r [4];
    logic [7:0] alm_nxt [4];

    // oscillator and pin settings
    logic gain_control_enable_r;
    logic gain_control_enable_nxt;
    logic osc_mode_select_r;
    logic osc_mode_select_nxt;
    logic bias_double_enable_r;
    logic bias_double_enable_nxt;
    logic low_freq_osc_select_r;
    logic low_freq_osc_select_nxt;
    logic crystal_mode_r;
    logic crystal_mode_nxt;
    logic osc_amplitude_valid_r;

    logic cap_auto_step_enable_r;
    logic cap_auto_step_enable_nxt;
    logic [3:0] load_cap_target_r;
    logic [3:0] load_cap_target_nxt;
    logic load_cap_ready_r;
    logic load_cap_ready_nxt;

    logic xtal_pin_short_r;
    logic xtal_pin_short_nxt;
    logic [6:0] pin_rsv_r;
    logic [6:0] pin_rsv_nxt;

    // decode nets
    logic req;
    logic wr;
    logic ctrl_wr;
    logic [3:0] idx;
    logic mapped;
    logic [31:0] timer_cnt;
    logic timer_match;
    logic timer_load;
    logic [31:0] cap_word;
    logic [31:0] alm_word;
    logic step_at_target;
    logic tgt_write;

    // a request is answered once; ack_r blocks the repeat cycle
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[5:2];
    assign mapped = (wb_adr_i[7:6] == 2'b00) && (idx <= `RTCC_IDX_LAST);

    assign cap_word = {cap_r[3], cap_r[2], cap_r[1], cap_r[0]}; // R9
    assign alm_word = {alm_r[3], alm_r[2], alm_r[1], alm_r[0]};
    assign timer_load = (op_r == rtcc_pkg::RTCC_OP_SET) && rtc_tick_i; // R7
    assign tgt_write = wr && mapped && (idx == `RTCC_IDX_OSCF);
    assign ctrl_wr = wr && mapped && (idx == `RTCC_IDX_CTRL);

    // tick counter and alarm match
    rtcc_timer #(
        .W(32)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(rtc_tick_i),
        .load_i(timer_load),
        .load_val_i(cap_word),
        .auto_rst_i(auto_reset_r),
        .alarm_i(alm_word),
        .count_o(timer_cnt),
        .match_o(timer_match)
    );

    // load cap stepping on slow ticks
    rtcc_cap_step #(
        .W(4),
        .RST_VAL(LOAD_CAP_RST)
    ) u_cap_step (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(rtc_tick_i),
        .step_en_i(cap_auto_step_enable_r),
        .target_i(load_cap_target_r),
        .applied_o(load_cap_o),
        .at_target_o(step_at_target)
    );

    // bus answer and read mux
    always_comb begin
        ack_nxt = req;
        rdat_nxt = rdat_r;
        // unused and unmapped bits read zero
        if (req) begin
            rdat_nxt = 32'h0000_0000;
            if (!mapped) begin
                rdat_nxt = 32'h0000_0000;
            end else if (idx < `RTCC_IDX_CTRL) begin
                rdat_nxt[7:0] = cap_r[idx[1:0]];
            end else if (idx == `RTCC_IDX_CTRL) begin
                rdat_nxt[`RTCC_CTRL_AEN] = alarm_enable_bit_r;
                rdat_nxt[`RTCC_CTRL_ALARM_FLAG_AUTORESET] = alarm_flag_r; // R3
                rdat_nxt[`RTCC_CTRL_SET] = timer_set_request_r;
                rdat_nxt[`RTCC_CTRL_CAP] = timer_capture_request_r;
            end else if (idx == `RTCC_IDX_OSCC) begin
                rdat_nxt[`RTCC_OSCC_AGC] = gain_control_enable_r;
                rdat_nxt[`RTCC_OSCC_MODE] = osc_mode_select_r;
                rdat_nxt[`RTCC_OSCC_BIAS] = bias_double_enable_r;
                rdat_nxt[`RTCC_OSCC_VALID] = osc_amplitude_valid_r; // R13
                rdat_nxt[`RTCC_OSCC_LFO] = low_freq_osc_select_r; // R15
            end else if (idx == `RTCC_IDX_OSCF) begin
                rdat_nxt[`RTCC_OSCF_STEP] = cap_auto_step_enable_r;
                rdat_nxt[`RTCC_OSCF_RDY] = load_cap_ready_r; // R17
                rdat_nxt[3:0] = load_cap_target_r; // R19
            end else if (idx == `RTCC_IDX_PIN) begin
                // shorting bit is write-only and reads zero
                rdat_nxt[6:0] = pin_rsv_r; // R21
            end else begin
                rdat_nxt[7:0] = alm_r[idx[1:0]];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // ack and data straight from flops
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // alarm, set/capture and oscillator configuration state
    always_comb begin
        alarm_enable_bit_nxt = alarm_enable_bit_r;
        auto_reset_nxt = auto_reset_r;
        alarm_flag_nxt = alarm_flag_r;
        timer_set_request_nxt = timer_set_request_r;
        timer_capture_request_nxt = timer_capture_request_r;
        op_nxt = op_r;
        cap_nxt = cap_r;
        alm_nxt = alm_r;

        gain_control_enable_nxt = gain_control_enable_r;
        osc_mode_select_nxt = osc_mode_select_r;
        bias_double_enable_nxt = bias_double_enable_r;
        low_freq_osc_select_nxt = low_freq_osc_select_r;

        cap_auto_step_enable_nxt = cap_auto_step_enable_r;
        load_cap_target_nxt = load_cap_target_r;
        xtal_pin_short_nxt = xtal_pin_short_r;
        pin_rsv_nxt = pin_rsv_r;

        // flag dies at the next tick; a fresh match wins the same tick
        if (rtc_tick_i) begin
            alarm_flag_nxt = 1'b0; // R6
        end

        // software writes, lane 0 only
        if (wr && mapped) begin
            if (idx < `RTCC_IDX_CTRL) begin
                cap_nxt[idx[1:0]] = wb_dat_i[7:0];
            end else if (idx == `RTCC_IDX_CTRL) begin
                alarm_enable_bit_nxt = wb_dat_i[`RTCC_CTRL_AEN]; // R1
                if (!wb_dat_i[`RTCC_CTRL_AEN]) begin
                    alarm_flag_nxt = 1'b0; // R2
                end
                auto_reset_nxt = wb_dat_i[`RTCC_CTRL_ALARM_FLAG_AUTORESET]; // R4
                if (wb_dat_i[`RTCC_CTRL_SET]) begin
                    timer_set_request_nxt = 1'b1; // R7
                end
                if (wb_dat_i[`RTCC_CTRL_CAP]) begin
                    timer_capture_request_nxt = 1'b1; // R8
                end
            end else if (idx == `RTCC_IDX_OSCC) begin
                gain_control_enable_nxt = wb_dat_i[`RTCC_OSCC_AGC]; // R10
                osc_mode_select_nxt = wb_dat_i[`RTCC_OSCC_MODE]; // R11
                bias_double_enable_nxt = wb_dat_i[`RTCC_OSCC_BIAS]; // R12
                low_freq_osc_select_nxt = wb_dat_i[`RTCC_OSCC_LFO]; // R14
            end else if (idx == `RTCC_IDX_OSCF) begin
                cap_auto_step_enable_nxt = wb_dat_i[`RTCC_OSCF_STEP]; // R16
                load_cap_target_nxt = wb_dat_i[3:0]; // R18
            end else if (idx == `RTCC_IDX_PIN) begin
                xtal_pin_short_nxt = wb_dat_i[`RTCC_PIN_SHORT]; // R20
                pin_rsv_nxt = wb_dat_i[6:0];
            end else begin
                alm_nxt[idx[1:0]] = wb_dat_i[7:0];
            end
        end

        // match sets the flag only while enabled, after any clear
        if (timer_match && alarm_enable_bit_nxt) begin
            alarm_flag_nxt = 1'b1; // R1
        end

        // transfers align to a slow tick, set before capture
        case (op_r)
            rtcc_pkg::RTCC_OP_IDLE: begin
                if (timer_set_request_r) begin
                    op_nxt = rtcc_pkg::RTCC_OP_SET;
                end else if (timer_capture_request_r) begin
                    op_nxt = rtcc_pkg::RTCC_OP_CAP;
                end
            end

            rtcc_pkg::RTCC_OP_SET: begin
                if (rtc_tick_i) begin
                    // a request written now survives
                    timer_set_request_nxt = ctrl_wr && wb_dat_i[`RTCC_CTRL_SET]; // R7
                    op_nxt = rtcc_pkg::RTCC_OP_IDLE;
                end
            end

            rtcc_pkg::RTCC_OP_CAP: begin
                if (rtc_tick_i) begin
                    for (int i = 0; i < 4; i++) begin
                        cap_nxt[i] = timer_cnt[8*i +: 8]; // R9
                    end
                    timer_capture_request_nxt = ctrl_wr && wb_dat_i[`RTCC_CTRL_CAP]; // R8
                    op_nxt = rtcc_pkg::RTCC_OP_IDLE;
                end
            end

            default: begin
                op_nxt = rtcc_pkg::RTCC_OP_IDLE;
            end
        endcase

        // slow internal osc overrides the mode bit
        crystal_mode_nxt = osc_mode_select_nxt && !low_freq_osc_select_nxt; // R14
        // a new target holds ready low for at least one cycle
        load_cap_ready_nxt = step_at_target && !tgt_write; // R22
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_enable_bit_r <= 1'b0;
            auto_reset_r <= 1'b0;
            alarm_flag_r <= 1'b0;
            timer_set_request_r <= 1'b0;
            timer_capture_request_r <= 1'b0;

            op_r <= rtcc_pkg::RTCC_OP_IDLE;
            for (int i = 0; i < 4; i++) begin
                cap_r[i] <= `RTCC_BYTE_RST;
                alm_r[i] <= `RTCC_BYTE_RST;
            end

            gain_control_enable_r <= 1'(`RTCC_OSCC_RST >> `RTCC_OSCC_AGC);
            osc_mode_select_r <= 1'b0;
            bias_double_enable_r <= 1'b0;
            low_freq_osc_select_r <= 1'b0;
            crystal_mode_r <= 1'b0;
            osc_amplitude_valid_r <= 1'b0;

            cap_auto_step_enable_r <= 1'b0;
            load_cap_target_r <= LOAD_CAP_RST;
            load_cap_ready_r <= 1'b0;
            xtal_pin_short_r <= 1'b0;
            pin_rsv_r <= PIN_RSV_RST;
        end else begin
            alarm_enable_bit_r <= alarm_enable_bit_nxt;
            auto_reset_r <= auto_reset_nxt;
            alarm_flag_r <= alarm_flag_nxt;
            timer_set_request_r <= timer_set_request_nxt;
            timer_capture_request_r <= timer_capture_request_nxt;

            op_r <= op_nxt;
            cap_r <= cap_nxt;
            alm_r <= alm_nxt;

            gain_control_enable_r <= gain_control_enable_nxt;
            osc_mode_select_r <= osc_mode_select_nxt;
            bias_double_enable_r <= bias_double_enable_nxt;
            low_freq_osc_select_r <= low_freq_osc_select_nxt;
            crystal_mode_r <= crystal_mode_nxt;
            osc_amplitude_valid_r <= osc_amp_ok_i; // R13

            cap_auto_step_enable_r <= cap_auto_step_enable_nxt;
            load_cap_target_r <= load_cap_target_nxt;
            load_cap_ready_r <= load_cap_ready_nxt;
            xtal_pin_short_r <= xtal_pin_short_nxt;
            pin_rsv_r <= pin_rsv_nxt;
        end
    end

    // outputs are register copies
    assign alarm_event_o = alarm_flag_r;
    assign agc_enable_o = gain_control_enable_r;
    assign crystal_mode_o = crystal_mode_r;
    assign bias_double_o = bias_double_enable_r;
    assign lfo_select_o = low_freq_osc_select_r;
    assign xtal_pin_short_o = xtal_pin_short_r;
endmodule // rtcc_ctrl
`default_nettype wire

// File: logic/rtcc_map.svh
// Purpose: register map, bit positions and reset values of the rtc control block
// Assumes: 32-bit word per register, byte address = 4 * index
// Notes: rules listed below
// Function
// R1: alarm events only while alarm enable set
// R2: clearing alarm enable clears alarm flag
// R3: control bit 2 reads live alarm flag
// R4: control bit 2 write stores auto-reset
// R5: auto-reset zeroes timer after each alarm
// R6: alarm flag lasts at most one tick
// R7: set bit loads timer, self-clears when done
// R8: capture bit copies timer, self-clears when done
// R9: full 32-bit move, low byte first
// R10: osc control bit 7 gain control enable
// R11: osc control bit 6 selects crystal mode
// R12: osc control bit 5 bias doubling enable
// R13: osc control bit 4 reads amplitude valid
// R14: osc control bit 3 overrides with slow oscillator
// R15: osc control bits 2:0 read zero
// R16: config bit 7 enables cap stepping
// R17: config bit 6 reads cap ready
// R18: config bits 3:0 hold cap target
// R19: config bits 5:4 read zero
// R20: pin config bit 7 shorts crystal pins
// R21: software read-modify-writes pin config
// R22: new target drops ready until applied
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

`define RTCC_IDX_CAP0 4'h0
`define RTCC_IDX_CTRL 4'h4
`define RTCC_IDX_OSCC 4'h5
`define RTCC_IDX_OSCF 4'h6
`define RTCC_IDX_PIN 4'h7
`define RTCC_IDX_ALM0 4'h8
`define RTCC_IDX_LAST 4'hB

`define RTCC_CTRL_AEN 3
`define RTCC_CTRL_ALARM_FLAG_AUTORESET 2
`define RTCC_CTRL_SET 1
`define RTCC_CTRL_CAP 0

`define RTCC_OSCC_AGC 7
`define RTCC_OSCC_MODE 6
`define RTCC_OSCC_BIAS 5
`define RTCC_OSCC_VALID 4
`define RTCC_OSCC_LFO 3

`define RTCC_OSCF_STEP 7
`define RTCC_OSCF_RDY 6

`define RTCC_PIN_SHORT 7

`define RTCC_OSCC_RST 8'h00
`define RTCC_BYTE_RST 8'h00

`endif

// File: logic/rtcc_pkg.sv
// Purpose: shared types of the rtc control block
// Assumes: nothing beyond the map header
// Notes: one-hot codes for the set/capture sequencer
package rtcc_pkg;
    typedef enum logic [2:0] {
        RTCC_OP_IDLE = 3'b001,
        RTCC_OP_SET = 3'b010,
        RTCC_OP_CAP = 3'b100
    } rtcc_op_t;
endpackage

// File: logic/rtcc_timer.sv
// Purpose: 32-bit timer counting rtc ticks, with load and alarm match
// Assumes: tick_i is a one-cycle pulse per slow clock period
// Notes: match is combinational, sampled by the parent
`timescale 1ns/10ps
`default_nettype none
module rtcc_timer #(
    parameter int W = 32
) (
    input wire logic clk_i,          // system clock
    input wire logic rst_i,          // sync reset
    input wire logic tick_i,         // slow clock tick
    input wire logic load_i,         // load pulse
    input wire logic [W-1:0] load_val_i, // value to load
    input wire logic auto_rst_i,     // zero on match
    input wire logic [W-1:0] alarm_i, // match value
    output logic [W-1:0] count_o,    // running count
    output logic match_o             // tick with count at alarm
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    assign match_o = tick_i && (count_r == alarm_i);
    assign count_o = count_r;

    always_comb begin
        count_nxt = count_r;
        if (load_i) begin
            count_nxt = load_val_i;
        end else if (match_o && auto_rst_i) begin
            count_nxt = '0; // R5
        end else if (tick_i) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule // rtcc_timer
`default_nettype wire

// File: logic/rtcc_cap_step.sv
// Purpose: steps applied load capacitance toward the target code
// Assumes: one step per slow tick
// Notes: disabled stepping applies the target at once
`timescale 1ns/10ps
`default_nettype none
module rtcc_cap_step #(
    parameter int W = 4,
    parameter logic [3:0] RST_VAL = 4'h0
) (
    input wire logic clk_i,          // system clock
    input wire logic rst_i,          // sync reset
    input wire logic tick_i,         // slow clock tick
    input wire logic step_en_i,      // stepping enable
    input wire logic [W-1:0] target_i, // programmed code
    output logic [W-1:0] applied_o,  // applied code
    output logic at_target_o         // applied equals target
);
    logic [W-1:0] applied_r;
    logic [W-1:0] applied_nxt;

    assign applied_o = applied_r;
    assign at_target_o = (applied_r == target_i);

    always_comb begin
        applied_nxt = applied_r;
        if (!step_en_i) begin
            applied_nxt = target_i; // R22
        end else if (tick_i && applied_r < target_i) begin
            applied_nxt = applied_r + 1'b1; // R16
        end else if (tick_i && applied_r > target_i) begin
            applied_nxt = applied_r - 1'b1; // R16
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            applied_r <= RST_VAL;
        end else begin
            applied_r <= applied_nxt;
        end
    end
endmodule // rtcc_cap_step
`default_nettype wire

// File: tb/rtcc_osc_model.sv
// Purpose: slow oscillator seen by the rtc control block
// Assumes: tick period and start-up time in system clocks
// Notes: amplitude drops at the next clock edge when powered down
`timescale 1ns/10ps
`default_nettype none
module rtcc_osc_model #(
    parameter int PERIOD = 10,
    parameter int START = 30
) (
    input wire logic clk_i,   // system clock
    input wire logic rst_i,   // sync reset
    input wire logic run_i,   // oscillator powered
    output logic tick_o,      // one pulse per slow period
    output logic amp_ok_o     // amplitude detector
);
    int cnt_r;
    int age_r;
    // a stopped oscillator gives no ticks, so transfers stall as on silicon
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= 0;
            age_r <= 0;
        end else begin
            cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
            age_r <= (age_r < START) ? age_r + 1 : age_r;
        end
    end
    assign tick_o = run_i && !rst_i && cnt_r == PERIOD - 1;
    assign amp_ok_o = age_r >= START;
endmodule // rtcc_osc_model
`default_nettype wire

// File: tb/rtcc_props.sv
// Purpose: port assertions of the rtc control block
// Assumes: write data held by the master through the ack cycle
// Notes: oscillator, pin and load cap write effects looked at two cycles after the taking edge, the alarm clear one cycle after
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_map.svh"
module rtcc_props (
    input wire logic clk_i,            // system clock
    input wire logic rst_i,            // sync reset
    input wire logic wb_cyc_i,         // bus cycle
    input wire logic wb_stb_i,         // strobe
    input wire logic wb_we_i,          // write enable
    input wire logic [3:0] wb_sel_i,   // byte lanes
    input wire logic [7:0] wb_adr_i,   // byte address
    input wire logic [31:0] wb_dat_i,  // write data
    input wire logic [31:0] wb_dat_o,  // read data
    input wire logic wb_ack_o,         // acknowledge
    input wire logic rtc_tick_i,       // slow tick
    input wire logic osc_amp_ok_i,     // amplitude detector
    input wire logic alarm_event_o,    // alarm flag
    input wire logic agc_enable_o,     // gain control
    input wire logic crystal_mode_o,   // crystal mode
    input wire logic bias_double_o,    // bias doubling
    input wire logic lfo_select_o,     // slow internal osc
    input wire logic xtal_pin_short_o, // pins shorted
    input wire logic [3:0] load_cap_o  // applied load cap
);
    localparam logic [5:0] A_CTRL = {2'h0, `RTCC_IDX_CTRL};
    localparam logic [5:0] A_OSCC = {2'h0, `RTCC_IDX_OSCC};
    localparam logic [5:0] A_OSCF = {2'h0, `RTCC_IDX_OSCF};
    localparam logic [5:0] A_PIN = {2'h0, `RTCC_IDX_PIN};
    logic take, wr, rd_ack, aen_r, aen_nxt;
    logic [5:0] ix;
    logic [7:0] wd_r, wd_nxt;
    assign ix = wb_adr_i[7:2];
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = take & wb_we_i & wb_sel_i[0];
    assign rd_ack = wb_ack_o & ~wb_we_i;
    // shadow of the enable bit, since the design keeps it internal
    always_comb begin
        aen_nxt = aen_r;
        wd_nxt = wr ? wb_dat_i[7:0] : wd_r;
        if (wr && ix == A_CTRL)
            aen_nxt = wb_dat_i[`RTCC_CTRL_AEN];
    end
    always_ff @(posedge clk_i) begin
        aen_r <= rst_i ? 1'b0 : aen_nxt;
        wd_r <= rst_i ? 8'h00 : wd_nxt;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_answer_a: assert property (take |=> wb_ack_o) else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    alarm_gate_a: assert property ($rose(alarm_event_o) |-> aen_r)
        else $error("alarm while disabled");
    alarm_clear_a: assert property (wr && ix == A_CTRL && !wb_dat_i[3] |=> !alarm_event_o)
        else $error("flag kept after disable");
    flag_read_a: assert property (rd_ack && ix == A_CTRL |->
        wb_dat_o[2] == $past(alarm_event_o)) else $error("flag read wrong");
    flag_short_a: assert property ($rose(alarm_event_o) |-> ##[1:40] !alarm_event_o)
        else $error("flag too long");
    amp_read_a: assert property (rd_ack && ix == A_OSCC |->
        wb_dat_o[4] == $past(osc_amp_ok_i, 2)) else $error("amplitude bit wrong");
    rsv_zero_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h000000 &&
        (ix != A_OSCC || wb_dat_o[2:0] == 3'h0) && (ix != A_OSCF || wb_dat_o[5:4] == 2'h0))
        else $error("unused bits not zero");
    osc_bits_a: assert property (wr && ix == A_OSCC |=> ##1
        agc_enable_o == wd_r[7] && bias_double_o == wd_r[5] && lfo_select_o == wd_r[3] &&
        crystal_mode_o == (wd_r[6] && !wd_r[3])) else $error("osc outputs wrong");
    pin_short_a: assert property (wr && ix == A_PIN |=> ##1 xtal_pin_short_o == wd_r[7])
        else $error("pin short wrong");
    cap_direct_a: assert property (wr && ix == A_OSCF && !wb_dat_i[7] |=>
        ##1 load_cap_o == wd_r[3:0]) else $error("load cap not applied");
    cover property ($rose(alarm_event_o));
    cover property (rd_ack && ix == A_CTRL && wb_dat_o[2]);
    cover property (wr && ix == A_OSCF && wb_dat_i[7]);
endmodule // rtcc_props
bind rtcc_ctrl rtcc_props i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
    .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rtc_tick_i, .osc_amp_ok_i, .alarm_event_o,
    .agc_enable_o, .crystal_mode_o, .bias_double_o, .lfo_select_o, .xtal_pin_short_o,
    .load_cap_o);
`default_nettype wire

// File: tb/testbench.sv
// Purpose: register level tests of the rtc control block
// Assumes: tick every 10 clocks from the oscillator model
// Notes: timer values checked through capture reads only
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
    logic [3:0] sel = 4'h0, lcap;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q, v;
    logic ack, aev, auto_gain_loop, xm, bias, internal_slow_oscillator, pshort, tick, amp;
    int bad_count = 0, n_checks = 0, cyc_cnt = 0;
    time t1;
    always #12.5 clk = ~clk;
    rtcc_osc_model #(.PERIOD(10), .START(30)) i_osc (.clk_i(clk), .rst_i(rst), .run_i(run),
        .tick_o(tick), .amp_ok_o(amp));
    rtcc_ctrl i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rtc_tick_i(tick), .osc_amp_ok_i(amp), .alarm_event_o(aev), .agc_enable_o(auto_gain_loop),
        .crystal_mode_o(xm), .bias_double_o(bias), .lfo_select_o(internal_slow_oscillator),
        .xtal_pin_short_o(pshort), .load_cap_o(lcap));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            bad_count++;
            $display("wrong value at %0t: run hung", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until ack is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        dat <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(q, {24'h000000, e});
    endtask
    task automatic put32(input logic [7:0] base, input logic [31:0] val);
        for (int i = 0; i < 4; i++)
            xfer(1'b1, base + 8'(4 * i), val[8 * i +: 8]);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        q = 32'hFFFFFFFF;
        while (q[b] !== 1'b0 && n < 50) begin
            xfer(1'b0, 8'h10, 8'h00);
            n++;
        end
        chk({31'h0, q[b]}, 32'h0);
    endtask
    task automatic wait_rise();
        int n;
        n = 0;
        while (aev === 1'b1)
            @(posedge clk);
        while (aev !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h10, 8'h00);
        rchk(8'h14, 8'h00);
        rchk(8'h1C, 8'h00);
        xfer(1'b1, 8'h30, 8'hFF);
        rchk(8'h30, 8'h00);
        $display("test reset done");
        xfer(1'b1, 8'h14, 8'hFF);
        rchk(8'h14, 8'hE8);
        chk({28'h0, auto_gain_loop, xm, bias, internal_slow_oscillator}, 32'hB);
        xfer(1'b1, 8'h14, 8'h40);
        rchk(8'h14, 8'h40);
        chk({28'h0, auto_gain_loop, xm, bias, internal_slow_oscillator}, 32'h4);
        run <= 1'b1;
        repeat (60) @(posedge clk);
        rchk(8'h14, 8'h50);
        $display("test osc done");
        xfer(1'b1, 8'h18, 8'h3A);
        rchk(8'h18, 8'h4A);
        chk({28'h0, lcap}, 32'hA);
        xfer(1'b1, 8'h18, 8'h83);
        rchk(8'h18, 8'h83);
        repeat (100) @(posedge clk);
        rchk(8'h18, 8'hC3);
        chk({28'h0, lcap}, 32'h3);
        xfer(1'b1, 8'h1C, 8'hD5);
        rchk(8'h1C, 8'h55);
        chk({31'h0, pshort}, 32'h1);
        xfer(1'b1, 8'h1C, q[7:0] & 8'h7F);
        rchk(8'h1C, 8'h55);
        chk({31'h0, pshort}, 32'h0);
        $display("test config done");
        // low byte near wrap so a carry must reach byte 1
        put32(8'h00, 32'h123456F8);
        xfer(1'b1, 8'h10, 8'h02);
        poll(1);
        repeat (90) @(posedge clk);
        xfer(1'b1, 8'h10, 8'h01);
        poll(0);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 8'(4 * i), 8'h00);
            v[8 * i +: 8] = q[7:0];
        end
        chk(32'(v > 32'h123456F8 && v < 32'h12345703), 32'h1);
        $display("test timer done");
        put32(8'h20, 32'h3);
        put32(8'h00, 32'h0);
        xfer(1'b1, 8'h10, 8'h0E);
        wait_rise();
        t1 = $time;
        wait_rise();
        chk(32'($time - t1), 32'h3E8);
        rchk(8'h10, 8'h0C);
        wait_rise();
        xfer(1'b1, 8'h10, 8'h04);
        chk({31'h0, aev}, 32'h0);
        rchk(8'h10, 8'h00);
        wait_rise();
        chk({31'h0, aev}, 32'h0);
        $display("test alarm done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
